// ==== src/dtt_consts.svh ====
// Constants for the dual 8-bit interval timer: register indices,
// field positions, reset values and prescaler terminal counts.
// Assumes inclusion by the design modules, the checker and the bench.
`ifndef DTT_CONSTS_SVH
`define DTT_CONSTS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define DTT_ADR_W      18
`define DTT_IDX_W      16
`define DTT_IDX_PFC    16'hfe42
`define DTT_IDX_CTRL   16'hfe78
`define DTT_IDX_PER_A  16'hfe7a
`define DTT_IDX_PER_B  16'hfe7b
`define DTT_IDX_CNT_A  16'hfe7c
`define DTT_IDX_CNT_B  16'hfe7d

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DTT_CTRL_B_SEL 7:6
`define DTT_CTRL_A_SEL 5:4
`define DTT_CTRL_B_OV  3
`define DTT_CTRL_B_IE  2
`define DTT_CTRL_A_OV  1
`define DTT_CTRL_A_IE  0
`define DTT_PFC_OE     7:6
`define DTT_PFC_CKO    3:0

// ----------------------------------------------------------------
// Reset values and prescaler terminal counts (4, 16, 64 cycles)
// ----------------------------------------------------------------
`define DTT_RST_REG    8'h00
`define DTT_PRE_END_4  6'h03
`define DTT_PRE_END_16 6'h0f
`define DTT_PRE_END_64 6'h3f

`endif

// ==== src/dtt_pkg.sv ====
// Types shared by the dual interval timer design.
// Assumes dtt_consts.svh is on the include path.
package dtt_pkg;

  // ----------------------------------------------------------------
  // Count clock selection
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DTT_SEL_STOP  = 2'b00,
    DTT_SEL_DIV4  = 2'b01,
    DTT_SEL_DIV16 = 2'b10,
    DTT_SEL_DIV64 = 2'b11
  } dtt_clksel_t;

  // ----------------------------------------------------------------
  // Bus and pin carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [17:0] adr;
    logic [31:0] dat;
  } dtt_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } dtt_wb_rsp_t;

  typedef struct packed {
    logic o;
    logic oe;
  } dtt_pin_t;

  // ----------------------------------------------------------------
  // Top-level state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] per_a;
    logic [7:0] per_b;
    logic [1:0] oe_en;
    logic [3:0] cko;
    logic       ack;
    logic [7:0] rdat;
    logic       irq;
  } dtt_top_st_t;

endpackage : dtt_pkg

// ==== src/dtt_timer.sv ====
// One interval timer channel: 6-bit prescaler, 8-bit counter,
// one-cycle overflow pulse and toggle waveform.
// Assumes select and period are held steady by the register file.
`include "dtt_consts.svh"

module dtt_timer #(
  parameter int PRE_W = 6,
  parameter int CNT_W = 8
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire dtt_pkg::dtt_clksel_t sel_i,
  input  wire logic [CNT_W-1:0]     period_i,
  input  wire logic                 restart_i,
  output logic [CNT_W-1:0]          cnt_o,
  output logic                      ovf_o,
  output logic                      wave_o
);
  import dtt_pkg::*;

  if (PRE_W < 6 || CNT_W < 1)
  begin : g_chk
    $error("dtt_timer: PRE_W must be at least 6, CNT_W at least 1");
  end

  typedef struct packed {
    logic [PRE_W-1:0] pre;
    logic [CNT_W-1:0] cnt;
    logic             ovf;
    logic             wave;
  } dtt_tmr_st_t;

  dtt_tmr_st_t      st_q;
  dtt_tmr_st_t      st_d;
  logic [PRE_W-1:0] pre_end;

  always_comb
  begin
    case (sel_i)
      DTT_SEL_DIV4:  pre_end = PRE_W'(`DTT_PRE_END_4);
      DTT_SEL_DIV16: pre_end = PRE_W'(`DTT_PRE_END_16);
      default:       pre_end = PRE_W'(`DTT_PRE_END_64);
    endcase
  end

  always_comb
  begin
    st_d     = st_q;
    st_d.ovf = 1'b0;
    if (sel_i == DTT_SEL_STOP)
    begin
      st_d.pre  = '0;
      st_d.cnt  = '0;
      st_d.wave = 1'b0;
    end
    else if (restart_i)
    begin
      st_d.pre = '0;
      st_d.cnt = '0;
    end
    else if (st_q.pre == pre_end)
    begin
      st_d.pre = '0;
      if (st_q.cnt == period_i)
      begin
        // Wrap one count clock after reaching the period: (R+1) ticks
        st_d.cnt  = '0;
        st_d.ovf  = 1'b1;
        st_d.wave = ~st_q.wave;
      end
      else
      begin
        st_d.cnt = st_q.cnt + CNT_W'(1);
      end
    end
    else
    begin
      st_d.pre = st_q.pre + PRE_W'(1);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign cnt_o  = st_q.cnt;
  assign ovf_o  = st_q.ovf;
  assign wave_o = st_q.wave;

endmodule // dtt_timer

// ==== src/dtt_pin.sv ====
// Port pin output stage: ORs a timer toggle onto the port latch.
// Assumes the port block supplies latch value and direction.
module dtt_pin (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         latch_i,
  input  wire logic         out_mode_i,
  input  wire logic         toggle_en_i,
  input  wire logic         wave_i,
  output dtt_pkg::dtt_pin_t pin_o
);
  import dtt_pkg::*;

  dtt_pin_t st_q;
  dtt_pin_t st_d;

  always_comb
  begin
    st_d.oe = out_mode_i;
    // Input mode: enable ignored, pin not driven
    if (out_mode_i)
    begin
      st_d.o = latch_i | (toggle_en_i & wave_i);
    end
    else
    begin
      st_d.o = 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign pin_o = st_q;

endmodule // dtt_pin

// ==== src/dtt_top.sv ====
// Dual 8-bit interval timer with toggle outputs and a shared
// interrupt request, reached over a classic Wishbone slave.
// Assumes one clock; port latch and direction come from port logic.
//
// What this block does
// - Timer B select 00 resets; else 4/16/64
// - Timer A select 00 resets; else 4/16/64
// - Timer B flag set once per period
// - Timer A flag set once per period
// - Timer B enable and flag raise interrupt
// - Timer A enable and flag raise interrupt
// - Timer A period is (R+1) times prescale
// - Timer B period is (R+1) times prescale
// - Timer A period write restarts from zero
// - Timer B period write restarts from zero
// - Timer B enable ignored in input mode
// - Timer B pin shows latch or toggle
// - Timer A enable ignored in input mode
// - Timer A pin shows latch or toggle
// - Port control: bit7 B, bit6 A enables
// - All registers reset to zero
// - Counter wraps one tick after period match
// - Six-bit prescaler divides the cycle clock
`include "dtt_consts.svh"

module dtt_top #(
  parameter int PRE_W = 6
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire dtt_pkg::dtt_wb_req_t wb_req_i,
  output dtt_pkg::dtt_wb_rsp_t      wb_rsp_o,
  input  wire logic [1:0]           port_latch_i,
  input  wire logic [1:0]           port_out_mode_i,
  output dtt_pkg::dtt_pin_t [1:0]   pin_o,
  output logic [3:0]                cko_ctrl_o,
  output logic                      irq_o
);
  import dtt_pkg::*;

  if (PRE_W < 6)
  begin : g_chk
    $error("dtt_top: PRE_W must be at least 6");
  end

  // ----------------------------------------------------------------
  // Address decode helper
  // ----------------------------------------------------------------
  function automatic logic hit(
    input logic [`DTT_ADR_W-1:0] adr,
    input logic [`DTT_IDX_W-1:0] idx
  );
    hit = (adr[`DTT_ADR_W-1:2] == idx);
  endfunction

  // ----------------------------------------------------------------
  // State and decode
  // ----------------------------------------------------------------
  dtt_top_st_t st_q;
  dtt_top_st_t st_d;

  logic       acc;
  logic       wr;
  logic       wr_ctrl;
  logic       wr_per_a;
  logic       wr_per_b;
  logic       wr_pfc;
  logic [1:0] restart;
  logic [1:0] ovf;
  logic [1:0] wave;
  logic [7:0] cnt_a;
  logic [7:0] cnt_b;

  // Accept while no ack is out; a held request is taken again every other cycle
  assign acc      = wb_req_i.cyc & wb_req_i.stb & ~st_q.ack;
  assign wr       = acc & wb_req_i.we & wb_req_i.sel[0];
  assign wr_ctrl  = wr & hit(wb_req_i.adr, `DTT_IDX_CTRL);
  assign wr_per_a = wr & hit(wb_req_i.adr, `DTT_IDX_PER_A);
  assign wr_per_b = wr & hit(wb_req_i.adr, `DTT_IDX_PER_B);
  assign wr_pfc   = wr & hit(wb_req_i.adr, `DTT_IDX_PFC);

  // Restart only while running; a stopped timer just stores the period
  assign restart[0] = wr_per_a &
                      (st_q.ctrl[`DTT_CTRL_A_SEL] != DTT_SEL_STOP);
  assign restart[1] = wr_per_b &
                      (st_q.ctrl[`DTT_CTRL_B_SEL] != DTT_SEL_STOP);

  // ----------------------------------------------------------------
  // Timer channels
  // ----------------------------------------------------------------
  dtt_timer #(
    .PRE_W (PRE_W),
    .CNT_W (8)
  ) u_timer_a (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .sel_i     (dtt_clksel_t'(st_q.ctrl[`DTT_CTRL_A_SEL])),
    .period_i  (st_q.per_a),
    .restart_i (restart[0]),
    .cnt_o     (cnt_a),
    .ovf_o     (ovf[0]),
    .wave_o    (wave[0])
  );

  dtt_timer #(
    .PRE_W (PRE_W),
    .CNT_W (8)
  ) u_timer_b (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .sel_i     (dtt_clksel_t'(st_q.ctrl[`DTT_CTRL_B_SEL])),
    .period_i  (st_q.per_b),
    .restart_i (restart[1]),
    .cnt_o     (cnt_b),
    .ovf_o     (ovf[1]),
    .wave_o    (wave[1])
  );

  // ----------------------------------------------------------------
  // Pin stages, index 0 timer A pin, index 1 timer B pin
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 2; i++)
  begin : g_pin
    dtt_pin u_pin (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .latch_i     (port_latch_i[i]),
      .out_mode_i  (port_out_mode_i[i]),
      .toggle_en_i (st_q.oe_en[i]),
      .wave_i      (wave[i]),
      .pin_o       (pin_o[i])
    );
  end

  // ----------------------------------------------------------------
  // Register file and bus response
  // ----------------------------------------------------------------
  always_comb
  begin
    st_d      = st_q;
    st_d.ack  = acc;
    st_d.rdat = 8'h00;

    if (wr_ctrl)
    begin
      st_d.ctrl = wb_req_i.dat[7:0];
    end
    // Hardware set wins over a clearing write in the same cycle
    if (ovf[1])
    begin
      st_d.ctrl[`DTT_CTRL_B_OV] = 1'b1;
    end
    if (ovf[0])
    begin
      st_d.ctrl[`DTT_CTRL_A_OV] = 1'b1;
    end

    if (wr_per_a)
    begin
      st_d.per_a = wb_req_i.dat[7:0];
    end
    if (wr_per_b)
    begin
      st_d.per_b = wb_req_i.dat[7:0];
    end
    if (wr_pfc)
    begin
      st_d.oe_en = wb_req_i.dat[`DTT_PFC_OE];
      st_d.cko   = wb_req_i.dat[`DTT_PFC_CKO];
    end

    // Unmapped or write access reads back zero
    if (acc && !wb_req_i.we)
    begin
      if (hit(wb_req_i.adr, `DTT_IDX_CTRL))
      begin
        st_d.rdat = st_q.ctrl;
      end
      else if (hit(wb_req_i.adr, `DTT_IDX_PER_A))
      begin
        st_d.rdat = st_q.per_a;
      end
      else if (hit(wb_req_i.adr, `DTT_IDX_PER_B))
      begin
        st_d.rdat = st_q.per_b;
      end
      else if (hit(wb_req_i.adr, `DTT_IDX_PFC))
      begin
        st_d.rdat = {st_q.oe_en, 2'b00, st_q.cko};
      end
      else if (hit(wb_req_i.adr, `DTT_IDX_CNT_A))
      begin
        st_d.rdat = cnt_a;
      end
      else if (hit(wb_req_i.adr, `DTT_IDX_CNT_B))
      begin
        st_d.rdat = cnt_b;
      end
      else
      begin
        st_d.rdat = 8'h00;
      end
    end

    // Shared request line for both timers
    st_d.irq = (st_d.ctrl[`DTT_CTRL_B_IE] & st_d.ctrl[`DTT_CTRL_B_OV]) |
               (st_d.ctrl[`DTT_CTRL_A_IE] & st_d.ctrl[`DTT_CTRL_A_OV]);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_q.ctrl  <= `DTT_RST_REG;
      st_q.per_a <= `DTT_RST_REG;
      st_q.per_b <= `DTT_RST_REG;
      st_q.oe_en <= 2'h0;
      st_q.cko   <= 4'h0;
      st_q.ack   <= 1'b0;
      st_q.rdat  <= 8'h00;
      st_q.irq   <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign wb_rsp_o.ack = st_q.ack;
  assign wb_rsp_o.dat = {24'h000000, st_q.rdat};
  assign cko_ctrl_o   = st_q.cko;
  assign irq_o        = st_q.irq;

endmodule // dtt_top

// ==== verif/dtt_top_properties.sv ====
// Port-level checks for the dual interval timer top.
// Assumes it is bound into dtt_top; one clock, sync reset.
`include "dtt_consts.svh"

module dtt_top_chk
  import dtt_pkg::*;
#(
  parameter int PRE_W = 6
) (
  input wire logic                    clk_i,
  input wire logic                    rst_i,
  input wire dtt_pkg::dtt_wb_req_t    wb_req_i,
  input wire dtt_pkg::dtt_wb_rsp_t    wb_rsp_o,
  input wire logic [1:0]              port_latch_i,
  input wire logic [1:0]              port_out_mode_i,
  input wire dtt_pkg::dtt_pin_t [1:0] pin_o,
  input wire logic [3:0]              cko_ctrl_o,
  input wire logic                    irq_o
);
  timeunit 1ns;
  timeprecision 1ns;

  logic        take;
  logic [15:0] idx;
  assign take = wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack;
  assign idx  = wb_req_i.adr[17:2];

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_ACK_NEXT: assert property (take |=> wb_rsp_o.ack)
    else $error("request not acked");
  AST_RD_UPPER: assert property (wb_rsp_o.ack |-> wb_rsp_o.dat[31:8] == 24'h000000)
    else $error("read data upper lanes nonzero");
  AST_RD_RSVD: assert property (
    wb_rsp_o.ack && $past(!wb_req_i.we && idx == `DTT_IDX_PFC) |-> wb_rsp_o.dat[5:4] == 2'b00)
    else $error("unused port bits read nonzero");
  AST_CKO_WR: assert property (
    wb_rsp_o.ack && $past(wb_req_i.we && wb_req_i.sel[0] && idx == `DTT_IDX_PFC)
    |-> cko_ctrl_o == $past(wb_req_i.dat[3:0])) else $error("clock out bits not stored");
  AST_IRQ_READ: assert property (
    wb_rsp_o.ack && $past(!wb_req_i.we && idx == `DTT_IDX_CTRL) |-> $past(irq_o) ==
    ((wb_rsp_o.dat[3] & wb_rsp_o.dat[2]) | (wb_rsp_o.dat[1] & wb_rsp_o.dat[0])))
    else $error("irq disagrees with flags");
  AST_IRQ_FALL: assert property (
    $fell(irq_o) |-> wb_rsp_o.ack && $past(wb_req_i.we && idx == `DTT_IDX_CTRL))
    else $error("irq dropped without write");
  AST_PIN_OE: assert property (
    pin_o[0].oe == $past(port_out_mode_i[0]) && pin_o[1].oe == $past(port_out_mode_i[1]))
    else $error("pin enable wrong");
  AST_PIN_IN: assert property (
    (pin_o[0].oe || !pin_o[0].o) && (pin_o[1].oe || !pin_o[1].o))
    else $error("input pin driven high");
  AST_PIN_LATCH: assert property (
    $past(port_out_mode_i[0] & port_latch_i[0]) <= pin_o[0].o &&
    $past(port_out_mode_i[1] & port_latch_i[1]) <= pin_o[1].o) else $error("latch lost");
  AST_RST: assert property (disable iff (1'b0)
    rst_i |=> !irq_o && cko_ctrl_o == 4'h0 && !wb_rsp_o.ack && pin_o == '0)
    else $error("outputs not cleared by reset");

endmodule // dtt_top_chk

bind dtt_top dtt_top_chk #(.PRE_W(PRE_W)) i_dtt_top_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o),
  .port_latch_i(port_latch_i), .port_out_mode_i(port_out_mode_i), .pin_o(pin_o),
  .cko_ctrl_o(cko_ctrl_o), .irq_o(irq_o));

// ==== verif/tb_top.sv ====
// Self-checking bench for the dual interval timer top.
// Assumes the checker binds itself; the bench drives all ports.
`include "dtt_consts.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import dtt_pkg::*;

  logic           clk_i = 1'b0;
  logic           rst_i = 1'b1;
  dtt_wb_req_t    req   = '0;
  dtt_wb_rsp_t    rsp;
  logic [1:0]     latch = 2'b00;
  logic [1:0]     mode  = 2'b00;
  dtt_pin_t [1:0] pin;
  logic [3:0]     cko;
  logic           irq;
  logic [7:0]     rd;
  logic [7:0]     ctl;
  logic           p1;
  logic [3:0]     wsel      = 4'hf;
  int             error_cnt = 0;
  int             n_checks  = 0;
  int             cyc_n     = 0;
  int             t1, t2, n;
  // Rows: index, write data, expected read back
  logic [31:0]    rows [7] = '{
    {`DTT_IDX_PFC, 8'hff, 8'hcf}, {`DTT_IDX_PER_A, 8'h5a, 8'h5a},
    {`DTT_IDX_PER_B, 8'ha5, 8'ha5}, {`DTT_IDX_CTRL, 8'h0a, 8'h0a},
    {`DTT_IDX_CTRL, 8'h0f, 8'h0f}, {16'hfe79, 8'hff, 8'h00},
    {`DTT_IDX_CNT_A, 8'hff, 8'h00}};

  dtt_top i_dtt_top (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp),
    .port_latch_i(latch), .port_out_mode_i(mode), .pin_o(pin), .cko_ctrl_o(cko),
    .irq_o(irq));

  initial forever #50 clk_i = ~clk_i;
  always @(posedge clk_i) cyc_n <= cyc_n + 1;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic ck(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1)
    begin
      error_cnt++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask

  // Waits on ack with no assumed latency; a 50-cycle bound ends a hang
  task automatic wb(input logic we, input logic [15:0] a, input logic [7:0] d,
                    output logic [7:0] q);
    int k;
    k = 0;
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: wsel, adr: {a, 2'b00}, dat: {24'h0, d}};
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (rsp.ack !== 1'b1 && k < 50);
    q = rsp.dat[7:0];
    ck(k < 50, "bus timeout");
    req.cyc <= 1'b0;
    req.stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wirq(output int t);
    int k;
    k = 0;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (irq !== 1'b1 && k < 1000);
    ck(k < 1000, "no interrupt");
    t = cyc_n;
  endtask

  task automatic zero_chk;
    logic [15:0] a [4] = '{`DTT_IDX_CTRL, `DTT_IDX_PER_A, `DTT_IDX_PER_B, `DTT_IDX_PFC};
    foreach (a[i])
    begin
      wb(1'b0, a[i], 8'h00, rd);
      ck(rd === 8'h00, "reset value");
    end
    ck(irq === 1'b0 && cko === 4'h0 && pin === '0, "reset outputs");
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (10000) @(posedge clk_i);
    error_cnt++;
    final_report();
  end

  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    zero_chk();
    foreach (rows[i])
    begin
      wb(1'b1, rows[i][31:16], rows[i][15:8], rd);
      wb(1'b0, rows[i][31:16], 8'h00, rd);
      ck(rd === rows[i][7:0], "register read");
    end
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    zero_chk();
    wb(1'b1, `DTT_IDX_PFC, 8'hc0, rd);
    // Lane 0 not selected: the write must be ignored
    wsel = 4'he;
    wb(1'b1, `DTT_IDX_PER_A, 8'h33, rd);
    wsel = 4'hf;
    wb(1'b0, `DTT_IDX_PER_A, 8'h00, rd);
    ck(rd === 8'h00, "write without lane 0 select landed");
    mode <= 2'b11;
    for (int t = 0; t < 2; t++)
      for (int s = 1; s < 4; s++)
      begin
        n = 4 ** s;
        ctl = 8'(s << (t ? 6 : 4)) | (t ? 8'h04 : 8'h01);
        wb(1'b1, 16'hfe7a + 16'(t), 8'h02, rd);
        wb(1'b1, `DTT_IDX_CTRL, ctl, rd);
        wirq(t1);
        p1 = pin[t].o;
        wb(1'b0, `DTT_IDX_CTRL, 8'h00, rd);
        ck(rd === (ctl | (t ? 8'h08 : 8'h02)), "overflow flag not set");
        wb(1'b1, `DTT_IDX_CTRL, ctl, rd);
        wirq(t2);
        ck(t2 - t1 == 3 * n, "overflow period");
        ck(p1 === 1'b1 && pin[t].o === 1'b0, "toggle level");
        if (s == 3)
        begin
          repeat (100) @(posedge clk_i);
          wb(1'b0, 16'hfe7c + 16'(t), 8'h00, rd);
          ck(rd === 8'h01, "count before restart");
          wb(1'b1, 16'hfe7a + 16'(t), 8'h02, rd);
          wb(1'b0, 16'hfe7c + 16'(t), 8'h00, rd);
          ck(rd === 8'h00, "count after restart");
        end
        wb(1'b1, `DTT_IDX_CTRL, 8'h00, rd);
        repeat (3) @(posedge clk_i);
        ck(pin[t].o === 1'b0 && irq === 1'b0, "stopped output");
      end
    latch <= 2'b11;
    repeat (3) @(posedge clk_i);
    ck(pin[0].o === 1'b1 && pin[1].o === 1'b1, "latch shown");
    mode <= 2'b00;
    repeat (3) @(posedge clk_i);
    ck(pin === '0, "input mode pins");
    final_report();
  end

endmodule // tb_top
